// ===== rtl/ssc_pkg.sv
package ssc_pkg;

    // ----------------------------------------------------------------
    // word framing
    // ----------------------------------------------------------------
    localparam int WORD_W = 24;

    // trailing address codes
    localparam logic [1:0] ADDR_DIV_RF = 2'h0;
    localparam logic [1:0] ADDR_GEN = 2'h1;
    localparam logic [1:0] ADDR_PUMP = 2'h2;
    localparam logic [2:0] ADDR_BW = 3'h3;
    localparam logic [3:0] ADDR_IFDIV = 4'h7;
    localparam logic [4:0] ADDR_IFREF = 5'hF;
    localparam logic [5:0] ADDR_TEST = 6'h1F;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int POS_PRESET_SEL = 23;
    localparam int POS_PRESET_IFPLL_FREQ_SEL = 23;
    localparam int POS_REF_SEL = 21;
    localparam int POS_SPUR = 12;
    localparam int POS_OBUF = 5;
    localparam int POS_RF_ON = 3;
    localparam int POS_IF_ON = 2;
    localparam int POS_PUMP = 23;
    localparam int POS_BW_HOLD = 23;
    localparam int POS_BW_WIN = 21;
    localparam int POS_BW_ON = 19;
    localparam int POS_OSC_CUR = 4;
    localparam int POS_SWALLOW = 16;
    localparam int POS_MAIN = 12;
    localparam int POS_REFDIV = 13;
    localparam int POS_TEST_DATA = 23;

    // ----------------------------------------------------------------
    // encodings and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] IFSEL_170M76 = 2'h0;
    localparam logic [1:0] IFSEL_367M20 = 2'h1;
    localparam logic [1:0] IFSEL_440M76 = 2'h2;
    localparam logic [1:0] PUMP_100UA = 2'h0;
    localparam logic [1:0] PUMP_800UA = 2'h3;
    localparam logic [3:0] SWALLOW_RST = 4'h0;
    localparam logic [8:0] MAIN_RST = 9'h001;
    localparam logic [8:0] MAIN_MIN = 9'h001;
    localparam logic [8:0] REFDIV_RST = 9'h002;
    localparam logic [8:0] REFDIV_MIN = 9'h002;

    typedef enum logic [1:0] {
        SSC_SPUR_OFF = 2'b00,
        SSC_SPUR_UNUSED = 2'b01,
        SSC_SPUR_TRACK = 2'b10,
        SSC_SPUR_ONCE = 2'b11
    } ssc_spur_t;

    typedef struct packed {
        logic [1:0] preset_ifpll_freq_sel;
        logic ref_clock_freq_sel;
        ssc_spur_t spur_scheme;
        logic [1:0] out_buffer_power;
        logic rf_synth_on;
        logic ifpll_on;
        logic [1:0] ifpll_pump_current;
        logic [1:0] loop_bw_hold_time;
        logic [1:0] loop_bw_phase_window;
        logic loop_bw_assist_on;
        logic [1:0] osc_core_current;
    } ssc_cfg_t;

    typedef struct packed {
        logic [3:0] swallow;
        logic [8:0] main_cnt;
        logic [8:0] ref_cnt;
    } ssc_div_t;

endpackage : ssc_pkg

// ===== rtl/ssc_config_bank.sv
module ssc_config_bank
    import ssc_pkg::*;
(
    input wire logic clk, // 20 MHz system clock
    input wire logic rstn, // async reset, active low
    input wire logic ser_clk, // serial clock pin
    input wire logic ser_data, // serial data pin
    input wire logic word_strobe, // latch strobe pin
    input wire logic use_preset_divisors, // preset flag from divider word
    output ssc_cfg_t cfg, // decoded configuration fields
    output ssc_div_t ifpll_div, // if divider values in effect
    output logic [WORD_W-1:0] test_word, // accepted test word
    output logic rf_synth_on, // rf synthesizer power
    output logic ifpll_on, // if loop power
    output logic bw_assist_active, // bandwidth assist applied
    output logic [12:0] ifpll_feedback_ratio // 16*main+swallow
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sck_sync;
        logic [2:0] stb_sync;
        logic [1:0] dat_sync;
        logic [WORD_W-1:0] shift;
        ssc_cfg_t cfg;
        ssc_div_t user_div;
        ssc_div_t div;
        logic [WORD_W-1:0] test;
        logic [12:0] ratio;
    } ssc_state_t;

    ssc_state_t st_ff;
    ssc_state_t nxt_st;

    localparam ssc_cfg_t CFG_RST = '{
        preset_ifpll_freq_sel: IFSEL_170M76,
        ref_clock_freq_sel: 1'b0,
        spur_scheme: SSC_SPUR_TRACK,
        out_buffer_power: 2'h0,
        rf_synth_on: 1'b0,
        ifpll_on: 1'b0,
        ifpll_pump_current: PUMP_100UA,
        loop_bw_hold_time: 2'h0,
        loop_bw_phase_window: 2'h0,
        loop_bw_assist_on: 1'b1,
        osc_core_current: 2'h3
    };
    localparam ssc_div_t DIV_RST = '{
        swallow: SWALLOW_RST,
        main_cnt: MAIN_RST,
        ref_cnt: REFDIV_RST
    };

    logic sck_rise;
    logic stb_rise;
    logic [WORD_W-1:0] w;
    logic [3:0] sw_f;
    logic [8:0] mn_f;
    logic [8:0] rf_f;
    ssc_div_t eff;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // pin inputs pass two flops; edges seen between the second and third stage (bits 1 and 2)
        nxt_st.sck_sync = {st_ff.sck_sync[1:0], ser_clk};
        nxt_st.stb_sync = {st_ff.stb_sync[1:0], word_strobe};
        nxt_st.dat_sync = {st_ff.dat_sync[0], ser_data};
        sck_rise = st_ff.sck_sync[1] & ~st_ff.sck_sync[2];
        stb_rise = st_ff.stb_sync[1] & ~st_ff.stb_sync[2];
        w = st_ff.shift;
        sw_f = w[POS_SWALLOW -: 4];
        mn_f = w[POS_MAIN -: 9];
        rf_f = w[POS_REFDIV -: 9];

        if (sck_rise) begin
            nxt_st.shift = {st_ff.shift[WORD_W-2:0], st_ff.dat_sync[1]};
        end

        if (stb_rise) begin
            if (w[5:0] == ADDR_TEST) begin
                nxt_st.test = w;
            end else if (w[4:0] == ADDR_IFREF) begin
                // out of range count keeps the previous value
                if (rf_f >= REFDIV_MIN) begin
                    nxt_st.user_div.ref_cnt = rf_f;
                end
            end else if (w[3:0] == ADDR_IFDIV) begin
                if (mn_f >= MAIN_MIN) begin
                    nxt_st.user_div.swallow = sw_f;
                    nxt_st.user_div.main_cnt = mn_f;
                end
            end else if (w[2:0] == ADDR_BW) begin
                nxt_st.cfg.loop_bw_hold_time = w[POS_BW_HOLD -: 2];
                nxt_st.cfg.loop_bw_phase_window = w[POS_BW_WIN -: 2];
                nxt_st.cfg.loop_bw_assist_on = w[POS_BW_ON];
                nxt_st.cfg.osc_core_current = w[POS_OSC_CUR -: 2];
            end else begin
                case (w[1:0])
                    ADDR_GEN: begin
                        nxt_st.cfg.preset_ifpll_freq_sel =
                            w[POS_PRESET_IFPLL_FREQ_SEL -: 2];
                        nxt_st.cfg.ref_clock_freq_sel = w[POS_REF_SEL];
                        nxt_st.cfg.spur_scheme =
                            ssc_spur_t'(w[POS_SPUR -: 2]);
                        nxt_st.cfg.out_buffer_power = w[POS_OBUF -: 2];
                        nxt_st.cfg.rf_synth_on = w[POS_RF_ON];
                        nxt_st.cfg.ifpll_on = w[POS_IF_ON];
                    end
                    ADDR_PUMP: begin
                        nxt_st.cfg.ifpll_pump_current = w[POS_PUMP -: 2];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // preset flag selects built-in divisors over host values
        eff = use_preset_divisors ? DIV_RST : st_ff.user_div;
        nxt_st.div = eff;
        if (use_preset_divisors) begin
            nxt_st.test = 24'h000000;
        end
        nxt_st.ratio = {eff.main_cnt, 4'h0} + {9'h000, eff.swallow};
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '{
                sck_sync: 3'h0, stb_sync: 3'h0, dat_sync: 2'h0,
                shift: 24'h000000, cfg: CFG_RST, user_div: DIV_RST,
                div: DIV_RST, test: 24'h000000,
                ratio: 13'h0010
            };
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cfg = st_ff.cfg;
    assign ifpll_div = st_ff.div;
    assign test_word = st_ff.test;
    assign rf_synth_on = st_ff.cfg.rf_synth_on;
    assign ifpll_on = st_ff.cfg.ifpll_on;
    assign bw_assist_active = st_ff.cfg.loop_bw_assist_on;
    assign ifpll_feedback_ratio = st_ff.ratio;

    // ----------------------------------------------------------------
    // checks: serial framing
    // ----------------------------------------------------------------
    a_shift_in: assert property (
        @(posedge clk) disable iff (!rstn)
        sck_rise |=> st_ff.shift ==
        {$past(st_ff.shift[WORD_W-2:0]), $past(st_ff.dat_sync[1])})
        else $error("serial bit not shifted in");

    a_shift_hold: assert property (
        @(posedge clk) disable iff (!rstn)
        !sck_rise
        |=> $stable(st_ff.shift))
        else $error("shift register moved without clock edge");

    a_no_strobe: assert property (
        @(posedge clk) disable iff (!rstn)
        !stb_rise
        |=> $stable(cfg))
        else $error("config changed without strobe");

    // ----------------------------------------------------------------
    // checks: word decode
    // ----------------------------------------------------------------
    a_gen_load: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[1:0] == ADDR_GEN
        |=> rf_synth_on == $past(w[3]) && ifpll_on == $past(w[2]))
        else $error("enable bits not loaded");

    a_if_preset: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[1:0] == ADDR_GEN
        |=> cfg.preset_ifpll_freq_sel == $past(w[23:22]))
        else $error("preset select not loaded");

    a_spur_load: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[1:0] == ADDR_GEN
        |=> cfg.spur_scheme == $past(w[12:11]))
        else $error("spur scheme not loaded");

    a_obuf_load: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[1:0] == ADDR_GEN
        |=> cfg.out_buffer_power == $past(w[5:4]))
        else $error("output power not loaded");

    a_ref_select: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[1:0] == ADDR_GEN
        |=> cfg.ref_clock_freq_sel == $past(w[21]))
        else $error("reference select not loaded");

    a_gen_keep: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[1:0] != ADDR_GEN
        |=> $stable({cfg.preset_ifpll_freq_sel, cfg.ref_clock_freq_sel,
        cfg.spur_scheme, cfg.out_buffer_power, rf_synth_on, ifpll_on}))
        else $error("general fields changed by another word");

    a_pump_load: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[1:0] == ADDR_PUMP
        |=> cfg.ifpll_pump_current == $past(w[23:22]))
        else $error("pump current not loaded");

    a_pump_keep: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[1:0] != ADDR_PUMP
        |=> $stable(cfg.ifpll_pump_current))
        else $error("pump current changed by another word");

    a_bw_load: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[2:0] == ADDR_BW
        |=> bw_assist_active == $past(w[19]))
        else $error("bandwidth enable not loaded");

    a_bw_hold: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[2:0] == ADDR_BW
        |=> cfg.loop_bw_hold_time == $past(w[23:22]))
        else $error("hold time not loaded");

    a_bw_window: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[2:0] == ADDR_BW
        |=> cfg.loop_bw_phase_window == $past(w[21:20]))
        else $error("phase window not loaded");

    a_osc_current: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[2:0] == ADDR_BW
        |=> cfg.osc_core_current == $past(w[4:3]))
        else $error("oscillator current not loaded");

    a_bw_keep: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[2:0] != ADDR_BW
        |=> $stable({cfg.loop_bw_hold_time, cfg.loop_bw_phase_window,
        bw_assist_active, cfg.osc_core_current}))
        else $error("bandwidth fields changed by another word");

    a_test_load: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[5:0] == ADDR_TEST && !use_preset_divisors
        |=> test_word == $past(w))
        else $error("test word not loaded");

    a_test_keep: assert property (
        @(posedge clk) disable iff (!rstn)
        !stb_rise && !use_preset_divisors
        |=> $stable(test_word))
        else $error("test word changed without strobe");

    // ----------------------------------------------------------------
    // checks: divider values
    // ----------------------------------------------------------------
    a_div_load: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[3:0] == ADDR_IFDIV && w[12:4] != 9'h000
        |=> st_ff.user_div.swallow == $past(w[16:13])
        && st_ff.user_div.main_cnt == $past(w[12:4]))
        else $error("divider counts not loaded");

    a_div_zero: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[3:0] == ADDR_IFDIV && w[12:4] == 9'h000
        |=> $stable(st_ff.user_div))
        else $error("zero main count accepted");

    a_ref_load: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[4:0] == ADDR_IFREF && w[13:5] >= REFDIV_MIN
        |=> st_ff.user_div.ref_cnt == $past(w[13:5]))
        else $error("reference count not loaded");

    a_ref_low: assert property (
        @(posedge clk) disable iff (!rstn)
        stb_rise && w[4:0] == ADDR_IFREF && w[13:5] < REFDIV_MIN
        |=> $stable(st_ff.user_div))
        else $error("low reference count accepted");

    a_preset_div: assert property (
        @(posedge clk) disable iff (!rstn)
        use_preset_divisors [*2]
        |-> ifpll_div == DIV_RST)
        else $error("preset divisors not applied");

    a_test_block: assert property (
        @(posedge clk) disable iff (!rstn)
        use_preset_divisors
        |=> test_word == 24'h000000)
        else $error("test word active with preset flag");

    a_user_div: assert property (
        @(posedge clk) disable iff (!rstn)
        !use_preset_divisors
        |=> ifpll_div == $past(st_ff.user_div))
        else $error("host divisors not applied");

    a_main_range: assert property (
        @(posedge clk) disable iff (!rstn)
        ifpll_div.main_cnt >= MAIN_MIN)
        else $error("main count out of range");

    a_ref_range: assert property (
        @(posedge clk) disable iff (!rstn)
        ifpll_div.ref_cnt >= REFDIV_MIN)
        else $error("reference count out of range");

    a_ratio_calc: assert property (
        @(posedge clk) disable iff (!rstn)
        ifpll_feedback_ratio ==
        13'(16 * ifpll_div.main_cnt) + 13'(ifpll_div.swallow))
        else $error("feedback ratio wrong");

endmodule : ssc_config_bank

// ===== dv/ssc_host_model.sv
module ssc_host_model (
    input wire logic clk, // system clock
    output logic ser_clk, // serial clock pin
    output logic ser_data, // serial data pin
    output logic word_strobe // latch strobe pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        word_strobe = 1'b0;
    end
    // serial clock stays low between frames; 4+4 clk gives 400 ns
    task automatic send_word(input logic [23:0] w);
        @(posedge clk);
        for (int i = 23; i >= 0; i--) begin
            // data moves with the falling edge, 4 clk before the rise
            ser_data <= w[i];
            repeat (4) @(posedge clk);
            ser_clk <= 1'b1;
            repeat (4) @(posedge clk);
            ser_clk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        // released data line must not keep looking like the last bit
        ser_data <= ~w[0];
        word_strobe <= 1'b1;
        repeat (5) @(posedge clk);
        word_strobe <= 1'b0;
    endtask : send_word
endmodule : ssc_host_model

// ===== dv/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ssc_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic flag = 1'b0;
    logic ser_clk, ser_data, word_strobe, rf_on, if_on, bw_on;
    ssc_cfg_t cfg, ecfg;
    ssc_div_t dv;
    logic [23:0] tw;
    logic [12:0] ratio;
    logic [31:0] lfsr = 32'h4C691F09;
    int n_fail = 0;
    int checks = 0;
    always #25 clk = ~clk;
    ssc_config_bank ssc_config_bank_i (.clk(clk), .rstn(rstn),
        .ser_clk(ser_clk), .ser_data(ser_data), .word_strobe(word_strobe),
        .use_preset_divisors(flag), .cfg(cfg), .ifpll_div(dv),
        .test_word(tw), .rf_synth_on(rf_on), .ifpll_on(if_on),
        .bw_assist_active(bw_on), .ifpll_feedback_ratio(ratio));
    ssc_host_model ssc_host_model_i (.clk(clk), .ser_clk(ser_clk),
        .ser_data(ser_data), .word_strobe(word_strobe));
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h0);
        return lfsr;
    endfunction : rnd
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic snd(input logic [23:0] w);
        ssc_host_model_i.send_word(w);
        repeat (10) @(posedge clk);
    endtask : snd
    task automatic stop_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [1:0] c;
        logic [31:0] r;
        logic [3:0] s;
        logic [8:0] m, rf;
        logic [23:0] w;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        ecfg = '0;
        ecfg.spur_scheme = SSC_SPUR_TRACK;
        ecfg.loop_bw_assist_on = 1'b1;
        ecfg.osc_core_current = 2'h3;
        chk(cfg, ecfg);
        chk(dv, {4'h0, 9'h001, 9'h002});
        chk(ratio, 13'h0010);
        chk(tw, 24'h0);
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            c = i[1:0];
            r = rnd();
            w = 24'h100141;
            w[23:22] = c;
            w[21] = r[0];
            w[12:11] = c + 2'h1;
            w[5:4] = c + 2'h2;
            w[3] = r[1];
            w[2] = r[2];
            snd(w);
            ecfg.preset_ifpll_freq_sel = c;
            ecfg.ref_clock_freq_sel = r[0];
            ecfg.spur_scheme = ssc_spur_t'(c + 2'h1);
            ecfg.out_buffer_power = c + 2'h2;
            ecfg.rf_synth_on = r[1];
            ecfg.ifpll_on = r[2];
            w = 24'h09DA8A;
            w[23:22] = c + 2'h3;
            snd(w);
            ecfg.ifpll_pump_current = c + 2'h3;
            w = 24'h05E8C3;
            w[23:22] = c;
            w[21:20] = c + 2'h1;
            w[19] = r[3];
            w[4:3] = c + 2'h2;
            snd(w);
            ecfg.loop_bw_hold_time = c;
            ecfg.loop_bw_phase_window = c + 2'h1;
            ecfg.loop_bw_assist_on = r[3];
            ecfg.osc_core_current = c + 2'h2;
            snd({r[23:2], 2'b00});
            chk(cfg, ecfg);
            chk(cfg, ecfg);
            chk({rf_on, if_on}, {r[1], r[2]});
            chk(bw_on, r[3]);
        end
        $display("test config words done");
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            m = 9'((r[15:0] % 511) + 1);
            rf = 9'((r[31:16] % 510) + 2);
            s = r[3:0];
            if (i == 0) {m, s, rf} = {9'h1FF, 4'hF, 9'h1FF};
            if (i == 1) {m, s, rf} = {9'h001, 4'h0, 9'h002};
            if ({5'h0, s} >= m) s = 4'(m - 9'h1);
            w = 24'h100007;
            w[16:13] = s;
            w[12:4] = m;
            snd(w);
            w = 24'h30800F;
            w[13:5] = rf;
            snd(w);
            chk(dv, {s, m, rf});
            chk(ratio, {m, 4'h0} + {9'h0, s});
        end
        snd(24'h100007);
        snd(24'h30802F);
        chk(dv, {s, m, rf});
        $display("test dividers done");
        @(posedge clk) flag <= 1'b1;
        snd(24'h80001F);
        chk(tw, 24'h0);
        chk(dv, {SWALLOW_RST, MAIN_RST, REFDIV_RST});
        chk(ratio, {MAIN_RST, 4'h0} + {9'h000, SWALLOW_RST});
        @(posedge clk) flag <= 1'b0;
        snd(24'h80001F);
        chk(tw, 24'h80001F);
        chk(dv, {s, m, rf});
        $display("test test word done");
        stop_test();
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        stop_test();
    end
endmodule : testbench
